// [hw/tlp_stream_tx_port.sv]
// Transmit streaming port: start-up guard, beat checker, lock-up and buffering FIFO.
`timescale 1ns/1ps

module tsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]    count_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0]         mem_q [DEPTH];
  logic [WIDTH-1:0]         mem_d [DEPTH];
  logic [AW-1:0]            wr_q, wr_d, rd_q, rd_d;
  logic [$clog2(DEPTH+1)-1:0] cnt_q, cnt_d;
  logic                     push, pop;

  // Natural pointer wrap only works for a power-of-two depth, so refuse anything else.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("tsp_fifo depth must be a power of two");
  end

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign count_o     = cnt_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and storage update; pointers wrap naturally at a power-of-two depth.
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d        = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cnt_q <= DEPTH) else $error("FIFO count above depth");
endmodule // tsp_fifo

module tlp_stream_tx_port #(
  parameter int unsigned PAYLOAD_W     = tsp_pkg::WIDTH_64,
  parameter int unsigned READY_LATENCY = tsp_pkg::LAT_DEFAULT,
  parameter int unsigned DEPTH         = tsp_pkg::FIFO_DEPTH
) (
  input  wire logic                 CLK_I,
  input  wire logic                 ARST_N_I,
  output logic                      XMIT_ACCEPT_READY_O,
  input  wire logic                 XMIT_BEAT_VALID_I,
  input  wire logic [PAYLOAD_W-1:0] XMIT_PAYLOAD_I,
  input  wire logic                 XMIT_FIRST_BEAT_I,
  input  wire logic                 XMIT_LAST_BEAT_I,
  input  wire logic                 XMIT_UPPER_HALF_EMPTY_I,
  output logic                      CORE_RESET_FLAG_O,
  output logic                      PORT_LOCKED_O,
  output logic                      LINK_VALID_O,
  input  wire logic                 LINK_READY_I,
  output logic [PAYLOAD_W-1:0]      LINK_PAYLOAD_O,
  output logic                      LINK_FIRST_O,
  output logic                      LINK_LAST_O,
  output logic                      LINK_UPPER_EMPTY_O
);
  localparam int unsigned DWB   = PAYLOAD_W / tsp_pkg::DW_BITS;
  localparam int unsigned SKID  = READY_LATENCY + tsp_pkg::DROP_MAX_CYC;
  localparam int unsigned FW    = PAYLOAD_W + 3;
  localparam int unsigned CW    = $clog2(DEPTH+1);
  localparam int unsigned SW    = $clog2(tsp_pkg::STARTUP_CYC+1);
  localparam logic [CW-1:0] ROOM_LIMIT = CW'(DEPTH - SKID);
  localparam logic [SW-1:0] START_DONE = SW'(tsp_pkg::STARTUP_CYC);

  // Bus width, latency and FIFO depth are limited to the configurations the datapath serves.
  if (PAYLOAD_W != tsp_pkg::WIDTH_64 && PAYLOAD_W != tsp_pkg::WIDTH_128 &&
      PAYLOAD_W != tsp_pkg::WIDTH_256) begin : g_bad_width
    $error("payload width must be 64, 128 or 256");
  end
  if (READY_LATENCY < tsp_pkg::LAT_MIN || READY_LATENCY > tsp_pkg::LAT_MAX) begin : g_bad_lat
    $error("ready latency must be 1 or 2");
  end
  if (DEPTH <= SKID + 1) begin : g_bad_depth
    $error("FIFO too shallow for the skid allowance");
  end

  // Beats needed for a dword total, rounded up to whole beats.
  function automatic logic [tsp_pkg::CNT_W-1:0] beats_for(input logic [tsp_pkg::CNT_W-1:0] dws);
    beats_for = tsp_pkg::CNT_W'((dws + tsp_pkg::CNT_W'(DWB - 1)) / tsp_pkg::CNT_W'(DWB));
  endfunction

  logic [SW-1:0]             start_q, start_d;
  logic                      flag_q, flag_d;
  logic                      ready_q, ready_d;
  logic                      lock_q, lock_d;
  logic                      in_pkt_q, in_pkt_d;
  logic [tsp_pkg::CNT_W-1:0] cnt_q, cnt_d, min_q, min_d, max_q, max_d;
  logic [tsp_pkg::CNT_W-1:0] cnt_new, lim_min, lim_max, hdr_dw, len_dw, tot_dw;
  logic [tsp_pkg::LEN_W-1:0] len_f;
  logic                      has_data, accept, err, fifo_in_ready, fifo_push;
  logic [FW-1:0]             fifo_out;
  logic [CW-1:0]             fifo_cnt;

  // Start-up sequence: the flag stays up until the guard count has run out.
  always_comb begin
    start_d = start_q;
    if (start_q != START_DONE) begin
      start_d = start_q + 1'b1;
    end
    flag_d = (start_d != START_DONE);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      start_q <= '0;
      flag_q  <= 1'b1;
    end else begin
      start_q <= start_d;
      flag_q  <= flag_d;
    end
  end

  // Beats are taken only with valid; during start-up or after lock-up they are ignored.
  assign accept  = XMIT_BEAT_VALID_I && !flag_q && !lock_q;
  // Expected beat range from header dword 0; alignment padding may add one dword.
  assign len_f    = XMIT_PAYLOAD_I[tsp_pkg::LEN_LSB +: tsp_pkg::LEN_W];
  assign has_data = XMIT_PAYLOAD_I[tsp_pkg::FMT_DATA_BIT];
  assign hdr_dw   = XMIT_PAYLOAD_I[tsp_pkg::FMT_4DW_BIT] ? tsp_pkg::CNT_W'(tsp_pkg::HDR_4DW)
                                                         : tsp_pkg::CNT_W'(tsp_pkg::HDR_3DW);
  assign len_dw   = !has_data ? '0 :
                    (len_f == '0) ? tsp_pkg::CNT_W'(tsp_pkg::MAX_LEN_DW) : tsp_pkg::CNT_W'(len_f);
  assign tot_dw   = hdr_dw + len_dw;
  assign cnt_new  = XMIT_FIRST_BEAT_I ? tsp_pkg::CNT_W'(1) : cnt_q + 1'b1;
  assign lim_min  = XMIT_FIRST_BEAT_I ? beats_for(tot_dw) : min_q;
  assign lim_max  = XMIT_FIRST_BEAT_I ? beats_for(tot_dw + tsp_pkg::CNT_W'(has_data)) : max_q;
  // Any framing or length fault, or a beat pushed while the FIFO is full, is fatal.
  assign err = accept && ((!XMIT_FIRST_BEAT_I && !in_pkt_q) ||
                          (XMIT_FIRST_BEAT_I && in_pkt_q) || !fifo_in_ready ||
                          (cnt_new > lim_max) ||
                          (XMIT_LAST_BEAT_I && cnt_new < lim_min));
  assign fifo_push = accept && !err;

  // Packet tracker and lock-up; only a reset leaves the locked state.
  always_comb begin
    in_pkt_d = in_pkt_q;
    cnt_d    = cnt_q;
    min_d    = min_q;
    max_d    = max_q;
    lock_d   = lock_q || err;
    if (fifo_push) begin
      in_pkt_d = !XMIT_LAST_BEAT_I;
      cnt_d    = cnt_new;
      min_d    = lim_min;
      max_d    = lim_max;
    end
    // Registered ready leaves room for the latency plus the slowest valid fall.
    ready_d = !flag_d && !lock_d && (fifo_cnt < ROOM_LIMIT);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      in_pkt_q <= 1'b0;
      cnt_q    <= '0;
      min_q    <= '0;
      max_q    <= '0;
      lock_q   <= 1'b0;
      ready_q  <= 1'b0;
    end else begin
      in_pkt_q <= in_pkt_d;
      cnt_q    <= cnt_d;
      min_q    <= min_d;
      max_q    <= max_d;
      lock_q   <= lock_d;
      ready_q  <= ready_d;
    end
  end

  assign XMIT_ACCEPT_READY_O = ready_q;
  assign CORE_RESET_FLAG_O   = flag_q;
  assign PORT_LOCKED_O       = lock_q;

  // The empty marker only means something on the last beat of 128-bit mode.
  tsp_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({XMIT_UPPER_HALF_EMPTY_I && XMIT_LAST_BEAT_I &&
                   (PAYLOAD_W == tsp_pkg::WIDTH_128),
                   XMIT_LAST_BEAT_I, XMIT_FIRST_BEAT_I, XMIT_PAYLOAD_I}),
    .out_valid_o (LINK_VALID_O),
    .out_ready_i (LINK_READY_I),
    .out_data_o  (fifo_out),
    .count_o     (fifo_cnt)
  );

  assign LINK_PAYLOAD_O     = fifo_out[PAYLOAD_W-1:0];
  assign LINK_FIRST_O       = fifo_out[PAYLOAD_W];
  assign LINK_LAST_O        = fifo_out[PAYLOAD_W+1];
  assign LINK_UPPER_EMPTY_O = fifo_out[PAYLOAD_W+2];

  // Checks on the port's own behaviour.
  lock_ready_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    lock_q |-> !XMIT_ACCEPT_READY_O) else $error("ready high while locked");
  lock_stay_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    lock_q |=> lock_q && !fifo_push) else $error("lock released or beat taken");
  bad_length_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (accept && XMIT_LAST_BEAT_I && cnt_new < lim_min) |=> lock_q [*2])
    else $error("short packet did not lock");
  start_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    flag_q |-> !XMIT_ACCEPT_READY_O) else $error("ready during start-up");
  flag_time_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    $fell(flag_q) |-> $past(flag_q, 1) && (start_q == START_DONE))
    else $error("reset flag fell at wrong time");
  ready_room_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    XMIT_ACCEPT_READY_O |-> $past(fifo_cnt) < ROOM_LIMIT) else $error("ready without room");
  full_drop_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    (fifo_cnt >= ROOM_LIMIT) |=> !XMIT_ACCEPT_READY_O) else $error("ready not dropped");
  capture_valid_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
    fifo_push |-> XMIT_BEAT_VALID_I && !flag_q) else $error("beat captured without valid");
  pkt_done_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    fifo_push && XMIT_LAST_BEAT_I && !XMIT_FIRST_BEAT_I);
  lock_hit_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I) $rose(lock_q));
  mid_stall_c: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    in_pkt_q && $fell(XMIT_ACCEPT_READY_O));
endmodule // tlp_stream_tx_port

// [hw/tsp_pkg.sv]
// Shared constants for the transmit streaming port.
package tsp_pkg;
  localparam int unsigned STARTUP_CYC  = 2;    // Cycles after reset release before beats count.
  localparam int unsigned DROP_MAX_CYC = 3;    // Worst case valid fall time after ready drops.
  localparam int unsigned LAT_MIN      = 1;
  localparam int unsigned LAT_MAX      = 2;
  localparam int unsigned LAT_DEFAULT  = 2;
  localparam int unsigned WIDTH_64     = 64;
  localparam int unsigned WIDTH_128    = 128;
  localparam int unsigned WIDTH_256    = 256;
  localparam int unsigned DW_BITS      = 32;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned LEN_LSB      = 0;    // Length field of header dword 0.
  localparam int unsigned LEN_W        = 10;
  localparam int unsigned FMT_DATA_BIT = 30;   // Packet carries payload.
  localparam int unsigned FMT_4DW_BIT  = 29;   // Header is four dwords.
  localparam int unsigned HDR_3DW      = 3;
  localparam int unsigned HDR_4DW      = 4;
  localparam int unsigned MAX_LEN_DW   = 1024; // A length field of zero means this many.
  localparam int unsigned CNT_W        = 11;   // Enough for the longest packet on 64 bits.
endpackage

// [verif/tb.sv]
// Self-checking bench for the transmit streaming port.
`timescale 1ns/1ps

module tb;
  localparam int unsigned W = tsp_pkg::WIDTH_64;
  localparam logic [31:0] HDRS [6] = '{32'h00000000, 32'h20000000, 32'h40000001,
                                       32'h60000002, 32'h40000008, 32'h60000000};
  logic          clk = 1'b0;
  logic          arst_n = 1'b0;
  logic          link_ready = 1'b0;
  logic          stall = 1'b0;
  logic          mon_en = 1'b1;
  logic          ready, valid, first, last, empty, flag, locked;
  logic          lvalid, lfirst, llast, lempty;
  logic [W-1:0]  data, ldata;
  logic [66:0]   exp_q[$];
  logic [16:0]   rnd = 17'h16b9b;
  int            miscompares = 0;
  int            num_checks = 0;

  tsp_app_model #(.W(W)) tsp_app_model_i (.clk_i(clk), .ready_i(ready), .rst_flag_i(flag),
    .valid_o(valid), .payload_o(data), .first_o(first), .last_o(last), .empty_o(empty));

  tlp_stream_tx_port #(.PAYLOAD_W(W), .READY_LATENCY(tsp_pkg::LAT_DEFAULT),
    .DEPTH(tsp_pkg::FIFO_DEPTH)) tlp_stream_tx_port_i (.CLK_I(clk), .ARST_N_I(arst_n),
    .XMIT_ACCEPT_READY_O(ready), .XMIT_BEAT_VALID_I(valid), .XMIT_PAYLOAD_I(data),
    .XMIT_FIRST_BEAT_I(first), .XMIT_LAST_BEAT_I(last), .XMIT_UPPER_HALF_EMPTY_I(empty),
    .CORE_RESET_FLAG_O(flag), .PORT_LOCKED_O(locked), .LINK_VALID_O(lvalid),
    .LINK_READY_I(link_ready), .LINK_PAYLOAD_O(ldata), .LINK_FIRST_O(lfirst),
    .LINK_LAST_O(llast), .LINK_UPPER_EMPTY_O(lempty));

  // A 25 ns period gives the 40 MHz clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Beats needed: header plus payload dwords, rounded up to whole bus words.
  function automatic int beats(input logic [31:0] h);
    int ln;
    ln = !h[tsp_pkg::FMT_DATA_BIT] ? 0 : (h[9:0] == 10'h000) ? 1024 : int'(h[9:0]);
    return ((h[tsp_pkg::FMT_4DW_BIT] ? 4 : 3) + ln + 1) / 2;
  endfunction

  task automatic chk_beat(input logic [66:0] e, input logic [66:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value link beat expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  // Queue n beats at the application and, if keep is set, note what must come out.
  task automatic send(input logic [31:0] h, input int n, input bit keep);
    logic [66:0] b;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      b = {rnd[3], i == 0, i == n - 1, {2{rnd[15:0], ~rnd[15:0]}}};
      if (i == 0) b[31:0] = h;
      tsp_app_model_i.q.push_back(b);
      b[66] = b[66] & b[64] & (W == tsp_pkg::WIDTH_128);
      if (keep) exp_q.push_back(b);
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge clk);
    chk_flag("all beats out", 1'b1, exp_q.size() == 0);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The far side drains at random, or not at all while stalled.
  always @(negedge clk) begin
    rnd = lfsr(rnd);
    link_ready <= !stall & rnd[0];
  end

  // While mon_en is set, every beat leaving the buffer must be the oldest one noted.
  always @(posedge clk) begin
    if (mon_en && lvalid === 1'b1 && link_ready) begin
      if (exp_q.size() == 0) chk_beat('x, {lempty, lfirst, llast, ldata});
      else chk_beat(exp_q.pop_front(), {lempty, lfirst, llast, ldata});
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    repeat (3) @(negedge clk);
    chk_flag("ready in reset", 1'b0, ready);
    chk_flag("flag in reset", 1'b1, flag);
    chk_flag("link valid in reset", 1'b0, lvalid);
    arst_n = 1'b1;
    @(negedge clk) chk_flag("flag after one edge", 1'b1, flag);
    @(negedge clk) chk_flag("flag after two edges", 1'b0, flag);
    foreach (HDRS[i]) send(HDRS[i], beats(HDRS[i]), 1'b1);
    drain();
    // Stalled far side: ready must fall before the buffer overflows.
    stall = 1'b1;
    send(32'h4000001e, beats(32'h4000001e), 1'b1);
    repeat (40) @(negedge clk);
    chk_flag("ready when full", 1'b0, ready);
    chk_flag("no lock on skid", 1'b0, locked);
    stall = 1'b0;
    drain();
    @(negedge clk);
    chk_flag("ready after drain", 1'b1, ready);
    // A packet four beats short hangs the port until reset.
    mon_en = 1'b0;
    send(32'h40000008, 2, 1'b0);
    send(32'h00000000, 2, 1'b0);
    repeat (30) @(negedge clk);
    chk_flag("locked on bad count", 1'b1, locked);
    chk_flag("ready when locked", 1'b0, ready);
    tsp_app_model_i.q.delete();
    arst_n = 1'b0;
    @(negedge clk) chk_flag("lock cleared by reset", 1'b0, locked);
    chk_flag("ready in second reset", 1'b0, ready);
    chk_flag("flag in second reset", 1'b1, flag);
    arst_n = 1'b1;
    @(negedge clk) chk_flag("flag one edge after second reset", 1'b1, flag);
    @(negedge clk) chk_flag("flag two edges after second reset", 1'b0, flag);
    @(negedge clk);
    mon_en = 1'b1;
    send(32'h60000002, beats(32'h60000002), 1'b1);
    drain();
    finish_test();
  end
endmodule // tb

// [verif/tsp_app_model.sv]
// Behavioural application logic that feeds packet beats into the transmit port.
`timescale 1ns/1ps

module tsp_app_model #(
  parameter int unsigned W = 64
) (
  input  wire logic         clk_i,
  input  wire logic         ready_i,
  input  wire logic         rst_flag_i,
  output logic              valid_o,
  output logic [W-1:0]      payload_o,
  output logic              first_o,
  output logic              last_o,
  output logic              empty_o
);
  logic [W+2:0] q[$]; // Beats queued by the bench: empty, first, last, payload.

  // Beats move only while ready is high and start-up is over.
  // Idle lines toggle so that a stale beat can never pass for a fresh one.
  always @(negedge clk_i) begin
    if (ready_i && !rst_flag_i && q.size() != 0) begin
      {empty_o, first_o, last_o, payload_o} = q.pop_front();
      valid_o = 1'b1;
    end else begin
      valid_o = 1'b0;
      {empty_o, first_o, last_o, payload_o} = ~{empty_o, first_o, last_o, payload_o};
    end
  end
endmodule // tsp_app_model
